// *** src/i2c_eeprom_defines.vh ***
`ifndef I2C_EEPROM_DEFINES_VH
`define I2C_EEPROM_DEFINES_VH

// ==========================================================
// clock and timing
// ==========================================================
`define CLK_PERIOD_NS 10
// internal programming time in ns; plain default, shorten via parameter
`define INTERNAL_PROGRAM_TIME_NS 5000000
// same time in clock cycles, sized to the busy counter (time / clock period)
`define PROG_CYCLES 20'h7a120
`define PROG_CNT_W 20

// ==========================================================
// select byte layout
// ==========================================================
`define SEL_TYPE_MSB 7
`define SEL_TYPE_LSB 4
`define SEL_STRAP_HIGH_BIT 3
`define SEL_STRAP_LOW_BIT 2
`define SEL_TOP_ADDR_BIT 1
`define SEL_DIR_BIT 0
// device-type code; value is arbitrary
`define DEV_TYPE_DEFAULT 4'h5

// ==========================================================
// byte framing and array
// ==========================================================
`define BITS_PER_BYTE 4'h8
`define ADDR_WIDTH 9
`define PAGE_BITS 4
`define DATA_WIDTH 8
`define ADDR_RESET 9'h000

`endif

// *** src/pin_sync3.v ***
// ==========================================================
// three-stage synchroniser with agreement filter
// ==========================================================
module pin_sync3 #(
	parameter WIDTH = 1
) (
	input wire clk, // sampling clock
	input wire rst, // synchronous reset
	input wire [WIDTH-1:0] async_in, // pins from outside
	input wire [WIDTH-1:0] reset_level, // level taken during reset
	output wire [WIDTH-1:0] sync_out // filtered level
);
	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;
	reg [WIDTH-1:0] level;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge clk) begin
				if (rst) begin
					// pins leave reset at their idle level, so no false edge follows reset
					stage1[i] <= reset_level[i];
					stage2[i] <= reset_level[i];
					stage3[i] <= reset_level[i];
					level[i] <= reset_level[i];
				end else begin
					stage1[i] <= async_in[i];
					stage2[i] <= stage1[i];
					stage3[i] <= stage2[i];
					// stage1 is read only by stage2; a change counts once 2 and 3 agree
					if (stage2[i] == stage3[i])
						level[i] <= stage3[i];
				end
			end
		end
	endgenerate
	assign sync_out = level;
endmodule // pin_sync3

// *** src/skid_buffer2.v ***
// ==========================================================
// two-entry buffer, registered head as output
// ==========================================================
module skid_buffer2 #(
	parameter WIDTH = 8
) (
	input wire clk, // clock
	input wire rst, // synchronous reset
	input wire in_valid, // producer offers a word
	output wire in_ready, // room for a word
	input wire [WIDTH-1:0] in_data, // producer word
	output reg out_valid, // head holds a word
	input wire out_ready, // consumer takes head
	output reg [WIDTH-1:0] out_data // head word
);
	reg [WIDTH-1:0] tail;
	reg tail_valid;
	wire pop = out_valid & out_ready;
	wire push = in_valid & ~tail_valid;
	assign in_ready = ~tail_valid;
	always @(posedge clk) begin
		if (rst) begin
			out_valid <= 1'b0;
			tail_valid <= 1'b0;
			out_data <= {WIDTH{1'b0}};
			tail <= {WIDTH{1'b0}};
		end else if (pop) begin
			if (tail_valid) begin
				out_data <= tail;
				tail_valid <= 1'b0;
			end else if (push) begin
				out_data <= in_data;
			end else begin
				out_valid <= 1'b0;
			end
		end else if (push) begin
			if (!out_valid) begin
				out_data <= in_data;
				out_valid <= 1'b1;
			end else begin
				tail <= in_data;
				tail_valid <= 1'b1;
			end
		end
	end
endmodule // skid_buffer2

// *** src/i2c_eeprom_slave_interface.v ***
`include "i2c_eeprom_defines.vh"

// Summary of operation
// - sample data on each serial clock rise
// - data pin only pulled low or released
// - start is data fall while clock high
// - ignore traffic until a start is seen
// - stop is data rise while clock high
// - stop after read no-ack means standby
// - receiver pulls data low in ninth slot
// - select byte msb first, fixed field layout
// - respond only when select bits match straps
// - select bit b1 is top address bit
// - direction bit one reads, zero writes
// - ack on match, else standby until start
// - protected upper half: no data ack, no write
// - unconnected write protect counts as low; no internal pull-down, the board must supply it
// - write: ack select, ack address, await data
// - program only on stop in tenth slot
// - busy programming: ignore bus entirely
// - reset brings block up in standby
// - sample protect from start to address end
// - page write wraps low four address bits
// - read address increments, wraps to zero
// - read no-ack in ninth slot ends transfer
module i2c_eeprom_slave_interface #(
	parameter [`PROG_CNT_W-1:0] PROG_CYCLES = `PROG_CYCLES,
	parameter [3:0] DEV_TYPE = `DEV_TYPE_DEFAULT // arbitrary code
) (
	input wire CLK_SYS, // system clock
	input wire RST, // synchronous reset, active high
	input wire SCL_IN, // serial clock pin
	input wire SDA_IN, // serial data pin level
	output reg SDA_OUT, // serial data drive value, always low
	output reg SDA_OE_N, // low while pulling data low
	input wire SELECT_STRAP_LOW, // strap compared with b2
	input wire SELECT_STRAP_HIGH, // strap compared with b3
	input wire UPPER_HALF_WRITE_PROTECT, // high protects upper half
	output reg [`ADDR_WIDTH-1:0] RD_ADDR, // array address counter
	input wire [`DATA_WIDTH-1:0] RD_DATA, // array byte at RD_ADDR
	output wire WR_VALID, // buffered write byte ready
	input wire WR_READY, // array latches take the byte
	output wire [`ADDR_WIDTH-1:0] WR_ADDR, // latch address
	output wire [`DATA_WIDTH-1:0] WR_DATA, // latch data
	output reg LATCH_CLEAR, // pulse: new write data phase
	output reg PROG_START, // pulse: commit latches to array
	output reg BUSY, // programming cycle in progress
	output reg SELECTED // high from a start until standby, low while busy
);
	// ==========================================================
	// states
	// ==========================================================
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_DEVSEL = 5'h02;
	localparam [4:0] ST_ADDR = 5'h04;
	localparam [4:0] ST_WDATA = 5'h08;
	localparam [4:0] ST_RDATA = 5'h10;

	// ==========================================================
	// pin synchronisation
	// ==========================================================
	wire [4:0] pins_sync;
	pin_sync3 #(
		.WIDTH(5)
	) u_sync (
		.clk(CLK_SYS),
		.rst(RST),
		.async_in({UPPER_HALF_WRITE_PROTECT, SELECT_STRAP_HIGH, SELECT_STRAP_LOW, SDA_IN, SCL_IN}),
		.reset_level(5'h03),
		.sync_out(pins_sync)
	);
	wire scl = pins_sync[0];
	wire sda = pins_sync[1];
	wire strap_low = pins_sync[2];
	wire strap_high = pins_sync[3];
	// a floating protect pin must be pulled down on the board side; low means writable
	wire wp_pin = pins_sync[4];

	// ==========================================================
	// bus condition detection
	// ==========================================================
	reg scl_d;
	reg sda_d;
	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire start_seen = scl & scl_d & sda_d & ~sda;
	wire stop_seen = scl & scl_d & ~sda_d & sda;

	// ==========================================================
	// write byte buffer
	// ==========================================================
	reg push_valid;
	reg [`ADDR_WIDTH+`DATA_WIDTH-1:0] push_word;
	wire buf_ready;
	skid_buffer2 #(
		.WIDTH(`ADDR_WIDTH + `DATA_WIDTH)
	) u_buf (
		.clk(CLK_SYS),
		.rst(RST),
		.in_valid(push_valid),
		.in_ready(buf_ready),
		.in_data(push_word),
		.out_valid(WR_VALID),
		.out_ready(WR_READY),
		.out_data({WR_ADDR, WR_DATA})
	);

	// ==========================================================
	// select byte decode
	// ==========================================================
	function select_match;
		input [7:0] sel;
		input s_high;
		input s_low;
		input [3:0] dtype;
		begin
			select_match = (sel[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == dtype) &&
				(sel[`SEL_STRAP_HIGH_BIT] == s_high) && (sel[`SEL_STRAP_LOW_BIT] == s_low);
		end
	endfunction

	// ==========================================================
	// bit slot decode
	// ==========================================================
	// the ninth slot follows eight data rises; used on both clock edges
	function byte_done;
		input [3:0] cnt;
		begin
			byte_done = (cnt == `BITS_PER_BYTE);
		end
	endfunction

	// ==========================================================
	// protocol engine
	// ==========================================================
	reg [4:0] state;
	reg [3:0] bit_cnt;
	reg [7:0] shreg;
	reg read_dir;
	reg ack_phase;
	reg ack_given;
	reg acked_data;
	reg wp_seen;
	reg prog_req;
	reg [`PROG_CNT_W-1:0] busy_cnt;
	// bus is deaf while a commit waits for the buffer to drain or programming runs
	wire bus_deaf = BUSY | prog_req;
	wire [`ADDR_WIDTH-1:0] next_addr = RD_ADDR + 9'h001;
	wire protected_target = RD_ADDR[`ADDR_WIDTH-1] & wp_seen;

	always @(posedge CLK_SYS) begin
		if (RST) begin
			// edge history starts at the idle-high bus levels
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			read_dir <= 1'b0;
			ack_phase <= 1'b0;
			ack_given <= 1'b0;
			acked_data <= 1'b0;
			wp_seen <= 1'b0;
			prog_req <= 1'b0;
			busy_cnt <= {`PROG_CNT_W{1'b0}};
			push_valid <= 1'b0;
			push_word <= {(`ADDR_WIDTH + `DATA_WIDTH){1'b0}};
			SDA_OUT <= 1'b0;
			SDA_OE_N <= 1'b1;
			RD_ADDR <= `ADDR_RESET;
			LATCH_CLEAR <= 1'b0;
			PROG_START <= 1'b0;
			BUSY <= 1'b0;
			SELECTED <= 1'b0;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			SDA_OUT <= 1'b0;
			push_valid <= 1'b0;
			LATCH_CLEAR <= 1'b0;
			PROG_START <= 1'b0;
			SELECTED <= (state != ST_IDLE) && !bus_deaf;
			// the commit waits until every latched byte has left the buffer
			if (prog_req && !WR_VALID && !push_valid) begin
				prog_req <= 1'b0;
				PROG_START <= 1'b1;
				BUSY <= 1'b1;
				busy_cnt <= PROG_CYCLES - 20'h00001;
			end else if (BUSY) begin
				if (busy_cnt == {`PROG_CNT_W{1'b0}})
					BUSY <= 1'b0;
				else
					busy_cnt <= busy_cnt - 20'h00001;
			end
			if (state == ST_DEVSEL || state == ST_ADDR)
				wp_seen <= wp_seen | wp_pin;
			if (bus_deaf) begin
				state <= ST_IDLE;
				SDA_OE_N <= 1'b1;
				ack_phase <= 1'b0;
			end else if (start_seen) begin
				// repeated start also lands here and restarts select decode
				state <= ST_DEVSEL;
				bit_cnt <= 4'h0;
				ack_phase <= 1'b0;
				acked_data <= 1'b0;
				wp_seen <= wp_pin;
				SDA_OE_N <= 1'b1;
			end else if (stop_seen) begin
				if (state == ST_WDATA && acked_data)
					prog_req <= 1'b1;
				state <= ST_IDLE;
				SDA_OE_N <= 1'b1;
				ack_phase <= 1'b0;
				acked_data <= 1'b0;
			end else if (state != ST_IDLE) begin
				if (scl_rise) begin
					// acked_data survives the tenth slot's rise, which a stop also carries
					if (!byte_done(bit_cnt)) begin
						shreg <= {shreg[6:0], sda};
						bit_cnt <= bit_cnt + 4'h1;
					end else begin
						bit_cnt <= 4'h0;
						if (state == ST_RDATA) begin
							RD_ADDR <= next_addr;
							if (sda)
								state <= ST_IDLE;
						end
					end
				end else if (scl_fall) begin
					// a stop only commits until the tenth slot's clock falls
					acked_data <= 1'b0;
					if (byte_done(bit_cnt) && !ack_phase) begin
						ack_phase <= 1'b1;
						ack_given <= 1'b0;
						SDA_OE_N <= 1'b1;
						case (state)
							ST_DEVSEL: begin
								if (select_match(shreg, strap_high, strap_low, DEV_TYPE)) begin
									SDA_OE_N <= 1'b0;
									RD_ADDR[`ADDR_WIDTH-1] <= shreg[`SEL_TOP_ADDR_BIT];
									read_dir <= shreg[`SEL_DIR_BIT];
								end else begin
									state <= ST_IDLE;
								end
							end
							ST_ADDR: begin
								SDA_OE_N <= 1'b0;
								RD_ADDR[`ADDR_WIDTH-2:0] <= shreg;
							end
							ST_WDATA: begin
								// a full buffer refuses the byte with no-ack rather than dropping it
								if (!protected_target && buf_ready) begin
									SDA_OE_N <= 1'b0;
									ack_given <= 1'b1;
									push_valid <= 1'b1;
									push_word <= {RD_ADDR, shreg};
									RD_ADDR[`PAGE_BITS-1:0] <= RD_ADDR[`PAGE_BITS-1:0] + 4'h1;
								end
							end
							ST_RDATA: begin
								SDA_OE_N <= 1'b1;
							end
							default: begin
								state <= ST_IDLE;
							end
						endcase
					end else if (ack_phase) begin
						ack_phase <= 1'b0;
						SDA_OE_N <= 1'b1;
						case (state)
							ST_DEVSEL: begin
								if (read_dir) begin
									state <= ST_RDATA;
									shreg <= RD_DATA;
									SDA_OE_N <= RD_DATA[7];
								end else begin
									state <= ST_ADDR;
								end
							end
							ST_ADDR: begin
								state <= ST_WDATA;
								LATCH_CLEAR <= 1'b1;
							end
							ST_WDATA: begin
								acked_data <= ack_given;
							end
							ST_RDATA: begin
								shreg <= RD_DATA;
								SDA_OE_N <= RD_DATA[7];
							end
							default: begin
								state <= ST_IDLE;
							end
						endcase
					end else if (state == ST_RDATA) begin
						SDA_OE_N <= shreg[7];
					end
				end
			end
		end
	end
endmodule // i2c_eeprom_slave_interface

// *** tb/i2c_eeprom_props_properties.sv ***
module i2c_eeprom_props #(
	parameter [19:0] PROG_CYCLES = 20'h000c8
) (
	input wire CLK_SYS, // clock
	input wire RST, // reset
	input wire SCL_IN, // serial clock
	input wire SDA_OUT, // drive value
	input wire SDA_OE_N, // drive enable
	input wire WR_VALID, // head valid
	input wire WR_READY, // head taken
	input wire [8:0] WR_ADDR, // head address
	input wire [7:0] WR_DATA, // head data
	input wire PROG_START, // commit pulse
	input wire BUSY, // programming
	input wire SELECTED // active
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// checks
	// ==========================================
	reg [19:0] busy_cnt;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	always @(posedge CLK_SYS) begin
		if (RST || !BUSY)
			busy_cnt <= 20'h00000;
		else
			busy_cnt <= busy_cnt + 20'h00001;
	end
	sequence s_commit;
		!WR_VALID ##1 BUSY;
	endsequence
	sequence s_stall;
		WR_VALID && !WR_READY;
	endsequence
	AST_OPEN_DRAIN: assert property (!SDA_OE_N |-> !SDA_OUT) else $error("data driven high");
	AST_BUSY_QUIET: assert property (BUSY |-> SDA_OE_N) else $error("drive while busy");
	AST_COMMIT: assert property (PROG_START |-> s_commit) else $error("bad commit");
	AST_BUSY_LEN: assert property ($fell(BUSY) |-> busy_cnt == PROG_CYCLES) else $error("busy length");
	AST_BUSY_MAX: assert property (busy_cnt <= PROG_CYCLES) else $error("busy too long");
	AST_ACK_LOW: assert property ($fell(SDA_OE_N) |-> !SCL_IN) else $error("drive with clock high");
	AST_HOLD: assert property (s_stall |=> WR_VALID && $stable(WR_ADDR) && $stable(WR_DATA))
		else $error("word lost");
	AST_RESET: assert property (disable iff (1'b0) RST |=> SDA_OE_N && !BUSY && !WR_VALID && !SELECTED)
		else $error("reset state");
endmodule // i2c_eeprom_props

bind i2c_eeprom_slave_interface i2c_eeprom_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.CLK_SYS, .RST,
	.SCL_IN, .SDA_OUT, .SDA_OE_N, .WR_VALID, .WR_READY, .WR_ADDR, .WR_DATA, .PROG_START, .BUSY, .SELECTED);

// *** tb/i2c_master_model.sv ***
module i2c_master_model (
	output logic scl, // serial clock
	output logic sda_low, // pulls data low
	input wire sda // resolved data wire
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// master bus cycles, clock idles high
	// ==========================================
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start;
		sda_low = 1'b0;
		#40 scl = 1'b1;
		#40 sda_low = 1'b1;
		#40 scl = 1'b0;
		#40;
	endtask
	task automatic stop;
		sda_low = 1'b1;
		#40 scl = 1'b1;
		#40 sda_low = 1'b0;
		#80;
	endtask
	task automatic bitx(input logic b, output logic r);
		sda_low = !b;
		#40 scl = 1'b1;
		#40 r = sda;
		#40 scl = 1'b0;
		#40;
	endtask
	// released ninth bit lets the device answer
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(last, r);
	endtask
endmodule // i2c_master_model

// *** tb/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam [19:0] PCYC = 20'h000c8;
	logic clk_sys, rst, strap_lo, strap_hi, wp, wr_ready, oe_n, sda_out, wr_valid;
	logic latch_clear, prog_start, busy, selected, scl, m_low, sda, a;
	logic [8:0] rd_addr, wr_addr;
	logic [7:0] rd_data, wr_data, q, sel;
	logic [3:0] i;
	logic [1:0] st;
	logic [2:0] ex;
	int n_mismatch, check_count, n_prog, exp_prog, n_clear;
	logic [12:0] rows [7] = '{{2'b10, 8'h58, 3'h3}, {2'b10, 8'h54, 3'h0}, {2'b01, 8'h56, 3'h6},
		{2'b01, 8'h54, 3'h7}, {2'b11, 8'h5e, 3'h3}, {2'b00, 8'h30, 3'h0}, {2'b00, 8'h50, 3'h3}};
	function automatic logic [7:0] rom(input logic [8:0] ad);
		return ad[7:0] ^ {ad[8], 7'h00} ^ 8'h5a;
	endfunction
	// ==========================================
	// wiring: pull-up data wire, array model
	// ==========================================
	assign sda = !(m_low || !oe_n);
	assign #1 rd_data = rom(rd_addr);
	i2c_master_model m (.scl(scl), .sda_low(m_low), .sda(sda));
	i2c_eeprom_slave_interface #(.PROG_CYCLES(PCYC)) dut (.CLK_SYS(clk_sys), .RST(rst), .SCL_IN(scl),
		.SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(oe_n), .SELECT_STRAP_LOW(strap_lo),
		.SELECT_STRAP_HIGH(strap_hi), .UPPER_HALF_WRITE_PROTECT(wp), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
		.WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
		.LATCH_CLEAR(latch_clear), .PROG_START(prog_start), .BUSY(busy), .SELECTED(selected));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = !clk_sys;
	end
	always @(posedge clk_sys) if (prog_start === 1'b1) n_prog++;
	always @(posedge clk_sys) if (latch_clear === 1'b1) n_clear++;
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// 0: buffer head valid, 1: busy, 2: busy over
	function automatic logic pick(input int s);
		return (s == 0) ? wr_valid : ((s == 1) ? busy : !busy);
	endfunction
	task automatic wait_hi(input int s);
		for (int k = 0; k < 400 && pick(s) !== 1'b1; k++) @(posedge clk_sys);
		#1;
		if (pick(s) !== 1'b1) begin
			n_mismatch++;
			$display("Error %0t: wait ran out", $time);
			print_verdict;
		end
	endtask
	task automatic sb(input logic [7:0] b, output logic ack);
		logic [7:0] d;
		m.xfer(b, 1'b1, d, ack);
		ack = !ack;
	endtask
	// ==========================================
	// main sequence
	// ==========================================
	initial begin
		{rst, strap_lo, strap_hi, wp, wr_ready} = 5'h10;
		repeat (5) @(posedge clk_sys);
		#1 chk({oe_n, busy, selected, wr_valid, rd_addr}, {4'h8, 9'h000});
		rst = 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
		for (i = 0; i < 7; i++) begin
			{st, sel, ex} = rows[i];
			{strap_hi, strap_lo} = st;
			wp = ex[2];
			m.start;
			sb(sel, a);
			chk(a, ex[1]);
			chk(selected, ex[1]);
			if (a) begin
				sb(8'h40 + i, a);
				chk(a, 1'b1);
				sb(8'hc0 + i, a);
				chk(a, ex[0]);
			end
			m.stop;
			if (a) begin
				wait_hi(0);
				chk({wr_addr, wr_data}, {sel[1], 8'h40 + i, 8'hc0 + i});
				exp_prog++;
				wr_ready = 1'b1;
				wait_hi(1);
				wait_hi(2);
				wr_ready = 1'b0;
			end else begin
				chk(wr_valid, 1'b0);
			end
		end
		m.start;
		sb(8'h50, a);
		sb(8'h07, a);
		sb(8'h99, a);
		wr_ready = 1'b1;
		m.stop;
		exp_prog++;
		wait_hi(1);
		m.start;
		sb(8'h50, a);
		chk(a, 1'b0);
		m.stop;
		wait_hi(2);
		m.start;
		sb(8'h50, a);
		chk(a, 1'b1);
		wr_ready = 1'b0;
		sb(8'h2f, a);
		sb(8'h11, a);
		sb(8'h22, a);
		chk(a, 1'b1);
		sb(8'h33, a);
		chk(a, 1'b0);
		m.stop;
		chk({wr_valid, wr_addr, wr_data}, {1'b1, 9'h02f, 8'h11});
		wr_ready = 1'b1;
		@(posedge clk_sys);
		#1 chk({wr_valid, wr_addr, wr_data}, {1'b1, 9'h020, 8'h22});
		@(posedge clk_sys);
		#1 chk(wr_valid, 1'b0);
		m.start;
		sb(8'h52, a);
		sb(8'hff, a);
		m.start;
		sb(8'h53, a);
		chk(a, 1'b1);
		chk(selected, 1'b1);
		m.xfer(8'hff, 1'b0, q, a);
		chk(q, rom(9'h1ff));
		m.xfer(8'hff, 1'b1, q, a);
		chk(q, rom(9'h000));
		m.stop;
		repeat (10) @(posedge clk_sys);
		#1 chk({oe_n, selected}, 2'b10);
		chk(n_prog, exp_prog);
		chk(n_clear, 8);
		print_verdict;
	end
endmodule // testbench
